// ### psc_top.sv
// power state coordinator: maps sleep and idle requests to clock, power and link states
`include "psc_params.svh"

module psc_top
   import psc_pkg::*;
(
   // clock and reset
   input wire logic i_sys_clk,
   input wire logic i_nrst,
   // platform sleep state and thread idle requests
   input wire psc_pkg::psc_sstate_t i_sleep_state,
   input wire psc_pkg::psc_cstate_t i_thr0_cstate,
   input wire psc_pkg::psc_cstate_t i_thr1_cstate,
   input wire logic i_ext_idle,
   // deep powerdown handshakes
   input wire logic i_flush_done,
   input wire logic [1:0] i_sram_save_done,
   input wire logic i_shrink_done,
   // memory controller status
   input wire logic i_mem_idle,
   input wire logic i_banks_open,
   // chipset link
   input wire logic i_link_idle,
   input wire logic i_link_pending,
   input wire logic i_link_at_l0,
   // core state and clock / power controls
   output psc_pkg::psc_cstate_t o_core_cstate,
   output logic o_core_clk_gate,
   output logic o_proc_clk_stop,
   output logic o_vcore_low,
   output logic o_vcore_off,
   output logic o_lfm_req,
   output logic o_uncore_pwr_off,
   output logic o_display_off,
   // deep powerdown sequencing
   output logic o_flush_req,
   output logic [1:0] o_sram_save_req,
   output logic o_l2_shrink_req,
   // memory
   output psc_pkg::psc_mem_t o_mem_state,
   output logic o_mem_cke,
   output logic o_mem_self_refresh,
   // chipset link
   output psc_pkg::psc_link_t o_chipset_link_state,
   output logic o_link_xfer_ok
);
   import psc_pkg::*;

   // ==========================================================
   // core idle resolution
   // the two thread requests fold into one core request; every departure from the
   // current core state except the wake from C6 first runs its latency budget, so a request that
   // flickers shorter than the budget never reaches the clock and voltage controls
   // limitation: a request that changes while a budget runs takes the running budget
   psc_cstate_t core_req;
   psc_cstate_t core_r;
   psc_dp_t dp_r;
   psc_dp_t dp_nxt;
   logic sleeping;
   logic [1:0] saved_r;
   logic lat_load;
   logic [`PSC_CNT_W-1:0] lat_count;
   logic lat_done;
   logic lat_armed_r;
   logic lat_elapsed;

   // shallower of both thread requests wins
   assign core_req = (i_thr0_cstate < i_thr1_cstate) ? i_thr0_cstate : i_thr1_cstate;
   assign sleeping = (i_sleep_state != PSC_S0);

   // latency budget per target depth, deeper is longer, except that C3 takes the C4 budget
   always_comb begin
      case (core_req)
         PSC_C1: lat_count = `PSC_CNT_W'(`PSC_LAT_C1_CYC);
         PSC_C2: lat_count = `PSC_CNT_W'(`PSC_LAT_C2_CYC);
         PSC_C3, PSC_C4: lat_count = `PSC_CNT_W'(`PSC_LAT_C4_CYC);
         PSC_C6: lat_count = `PSC_CNT_W'(`PSC_LAT_C6_CYC);
         default: lat_count = `PSC_CNT_W'(1);
      endcase
   end

   // a new budget starts whenever the resolved request departs from the current state while no budget runs and the deep sequence is in run;
   // the armed flag keeps the idle zero of the timer from counting as an elapsed budget
   assign lat_load = (core_req != core_r) && lat_done && !lat_armed_r && (dp_r == PSC_DP_RUN);
   assign lat_elapsed = lat_done && lat_armed_r;

   // armed from the load edge until the timer has run out
   always_ff @(posedge i_sys_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         lat_armed_r <= 1'b0;
      end else if (lat_load) begin
         lat_armed_r <= 1'b1;
      end else if (lat_done) begin
         lat_armed_r <= 1'b0;
      end
   end

   psc_lat_timer u_lat (
      .i_sys_clk(i_sys_clk),
      .i_nrst(i_nrst),
      .i_load(lat_load),
      .i_count(lat_count),
      .o_done(lat_done)
   );

   // core state moves only once the entry/exit budget has elapsed, except the exit from C6, which goes to C0 through the wake step
   always_ff @(posedge i_sys_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         core_r <= PSC_C0;
      end else if (dp_r == PSC_DP_WAKE) begin
         core_r <= PSC_C0;
      end else if (dp_r == PSC_DP_RUN && lat_elapsed && core_req != PSC_C6) begin
         core_r <= core_req;
      end else if (dp_r == PSC_DP_OFF) begin
         core_r <= PSC_C6;
      end
   end

   // ==========================================================
   // deepest idle sequence
   // the sequence only starts once the running budget has run out with C6 requested and the platform is awake;
   // the thread saves start with the thread requests, ahead of the flush, so the save step usually passes in one cycle
   // limitation: once started, the sequence finishes its steps before it looks at a wake
   // outside sleep states, voltage is removed only after flush and both saves finish
   always_comb begin
      dp_nxt = dp_r;
      case (dp_r)
         PSC_DP_RUN: if (core_req == PSC_C6 && lat_elapsed && !sleeping) dp_nxt = PSC_DP_FLUSH;
         PSC_DP_FLUSH: if (i_flush_done) dp_nxt = PSC_DP_SAVE;
         PSC_DP_SAVE: if (saved_r == 2'h3) dp_nxt = PSC_DP_SHRINK;
         PSC_DP_SHRINK: if (i_shrink_done) dp_nxt = PSC_DP_OFF;
         PSC_DP_OFF: if (core_req != PSC_C6) dp_nxt = PSC_DP_WAKE;
         PSC_DP_WAKE: dp_nxt = PSC_DP_RUN;
         default: dp_nxt = PSC_DP_RUN;
      endcase
   end

   always_ff @(posedge i_sys_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         dp_r <= PSC_DP_RUN;
      end else begin
         dp_r <= dp_nxt;
      end
   end

   // each thread saves into its own SRAM as soon as it asks for deep powerdown
   // a save only counts while its thread still asks for it: a thread that ran code again
   // has a stale copy, and removing voltage on it would lose context
   // a save finishing in the same cycle as a clear wins, so no finished save is lost
   always_ff @(posedge i_sys_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         saved_r <= 2'h0;
      end else begin
         saved_r[0] <= i_sram_save_done[0] ||
                       (saved_r[0] && i_thr0_cstate == PSC_C6 && dp_r != PSC_DP_WAKE);
         saved_r[1] <= i_sram_save_done[1] ||
                       (saved_r[1] && i_thr1_cstate == PSC_C6 && dp_r != PSC_DP_WAKE);
      end
   end

   // save requests are per thread, independent of the other thread
   always_ff @(posedge i_sys_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_sram_save_req <= 2'h0;
      end else begin
         o_sram_save_req[0] <= (i_thr0_cstate == PSC_C6) && !saved_r[0] && !i_sram_save_done[0];
         o_sram_save_req[1] <= (i_thr1_cstate == PSC_C6) && !saved_r[1] && !i_sram_save_done[1];
      end
   end

   // flush, then shrink by the last thread in, then power off
   always_ff @(posedge i_sys_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_flush_req <= 1'b0;
         o_l2_shrink_req <= 1'b0;
         o_vcore_off <= 1'b0;
      end else begin
         o_flush_req <= (dp_nxt == PSC_DP_FLUSH);
         o_l2_shrink_req <= (dp_nxt == PSC_DP_SHRINK);
         o_vcore_off <= (dp_nxt == PSC_DP_OFF) || sleeping;
      end
   end

   // ==========================================================
   // clock and voltage controls
   // all controls follow the settled core state, never the raw thread requests, and o_lfm_req also follows i_ext_idle directly, so
   // o_core_clk_gate, o_proc_clk_stop and o_vcore_low only move once a latency budget has been honoured or a wake from C6 has begun
   always_ff @(posedge i_sys_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_core_cstate <= PSC_C0;
         o_core_clk_gate <= 1'b0;
         o_proc_clk_stop <= 1'b0;
         o_vcore_low <= 1'b0;
         o_lfm_req <= 1'b0;
      end else begin
         o_core_cstate <= core_r;
         o_core_clk_gate <= (core_r >= PSC_C2);
         o_proc_clk_stop <= (core_r >= PSC_C3);
         o_vcore_low <= (core_r >= PSC_C3) && (core_r != PSC_C6);
         // extended variants drop to low frequency/voltage point
         o_lfm_req <= i_ext_idle && (core_r == PSC_C1 || core_r == PSC_C2 ||
                      core_r == PSC_C4);
      end
   end

   // sleep states shut display, uncore and core power
   always_ff @(posedge i_sys_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_display_off <= 1'b0;
         o_uncore_pwr_off <= 1'b0;
      end else begin
         o_display_off <= sleeping;
         o_uncore_pwr_off <= sleeping;
      end
   end

   // ==========================================================
   // memory power states
   // the mode is picked fresh every cycle from traffic and bank status; sleep states
   // always end in self-refresh, since clock enable low alone would let memory decay
   psc_mem_t mem_nxt;

   // suspend to RAM holds context in self-refresh memory
   always_comb begin
      if (i_sleep_state == PSC_S3) begin
         mem_nxt = PSC_MEM_SR;
      end else if (sleeping) begin
         mem_nxt = PSC_MEM_SR;
      end else if (!i_mem_idle) begin
         mem_nxt = PSC_MEM_UP;
      end else if (i_banks_open) begin
         mem_nxt = PSC_MEM_APD;
      end else begin
         mem_nxt = PSC_MEM_PPD;
      end
   end

   // cke only high in the active state; self-refresh flag only in SR
   always_ff @(posedge i_sys_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_mem_state <= PSC_MEM_UP;
         o_mem_cke <= 1'b1;
         o_mem_self_refresh <= 1'b0;
      end else begin
         o_mem_state <= mem_nxt;
         o_mem_cke <= (mem_nxt == PSC_MEM_UP);
         o_mem_self_refresh <= (mem_nxt == PSC_MEM_SR);
      end
   end

   // ==========================================================
   // chipset link power states
   // priority runs sleep, then traffic, then depth: a sleeping platform powers the link
   // off even with a transfer pending, since nothing on the far side can take it
   psc_link_t link_nxt;

   // outside sleep, pending traffic forces full-on first; L1 is only legal at C2..C4
   always_comb begin
      if (sleeping) begin
         link_nxt = PSC_L3;
      end else if (i_link_pending || !i_link_idle) begin
         link_nxt = PSC_L0;
      end else if (core_r >= PSC_C2 && core_r <= PSC_C4) begin
         link_nxt = PSC_L1;
      end else begin
         link_nxt = PSC_L0S;
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_chipset_link_state <= PSC_L0;
      end else begin
         o_chipset_link_state <= link_nxt;
      end
   end

   // transfers wait until the link reports L0 again
   assign o_link_xfer_ok = (o_chipset_link_state == PSC_L0) && i_link_at_l0;
endmodule

// ### psc_params.svh
// timing counts and counter width for the power state coordinator
`ifndef PSC_PARAMS_SVH
`define PSC_PARAMS_SVH

`define PSC_CLK_MHZ 40
// entry/exit latency budgets in ns, deeper states longer
`define PSC_LAT_C1_NS 100
`define PSC_LAT_C2_NS 500
`define PSC_LAT_C4_NS 2000
`define PSC_LAT_C6_NS 10000
`define PSC_LAT_L1_NS 1000
// cycle counts, rounded up, at least one
`define PSC_CYC(ns) ((((ns) * `PSC_CLK_MHZ) + 999) / 1000)
`define PSC_LAT_C1_CYC `PSC_CYC(`PSC_LAT_C1_NS)
`define PSC_LAT_C2_CYC `PSC_CYC(`PSC_LAT_C2_NS)
`define PSC_LAT_C4_CYC `PSC_CYC(`PSC_LAT_C4_NS)
`define PSC_LAT_C6_CYC `PSC_CYC(`PSC_LAT_C6_NS)
`define PSC_LAT_L1_CYC `PSC_CYC(`PSC_LAT_L1_NS)
`define PSC_CNT_W 9

`endif

// ### psc_pkg.sv
// types of the power state coordinator
package psc_pkg;
   // core idle levels, ordered so that numeric compare gives depth
   typedef enum logic [2:0] {
      PSC_C0 = 3'h0,
      PSC_C1 = 3'h1,
      PSC_C2 = 3'h2,
      PSC_C3 = 3'h3,
      PSC_C4 = 3'h4,
      PSC_C6 = 3'h6
   } psc_cstate_t;
   typedef enum logic [2:0] {
      PSC_S0 = 3'h0,
      PSC_S3 = 3'h3,
      PSC_S4 = 3'h4,
      PSC_S5 = 3'h5
   } psc_sstate_t;
   typedef enum logic [1:0] {
      PSC_L0 = 2'h0,
      PSC_L0S = 2'h1,
      PSC_L1 = 2'h2,
      PSC_L3 = 2'h3
   } psc_link_t;
   typedef enum logic [1:0] {
      PSC_MEM_UP = 2'h0,
      PSC_MEM_PPD = 2'h1,
      PSC_MEM_APD = 2'h2,
      PSC_MEM_SR = 2'h3
   } psc_mem_t;
   // deep powerdown sequence, gray along the entry path
   typedef enum logic [2:0] {
      PSC_DP_RUN = 3'h0,
      PSC_DP_FLUSH = 3'h1,
      PSC_DP_SAVE = 3'h3,
      PSC_DP_SHRINK = 3'h2,
      PSC_DP_OFF = 3'h6,
      PSC_DP_WAKE = 3'h7
   } psc_dp_t;
endpackage

// ### psc_lat_timer.sv
// latency budget timer: counts a load value down to zero
`include "psc_params.svh"

module psc_lat_timer (
   // clock and reset
   input wire logic i_sys_clk,
   input wire logic i_nrst,
   // control
   input wire logic i_load,
   input wire logic [`PSC_CNT_W-1:0] i_count,
   // status
   output logic o_done
);
   logic [`PSC_CNT_W-1:0] cnt_r;

   // reload wins over counting so a new budget always restarts
   always_ff @(posedge i_sys_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         cnt_r <= '0;
      end else if (i_load) begin
         cnt_r <= i_count;
      end else if (cnt_r != '0) begin
         cnt_r <= cnt_r - `PSC_CNT_W'(1);
      end
   end

   // done looks at the count alone; folding the load in here would close a loop through
   // the caller, whose load itself waits for done
   assign o_done = (cnt_r == '0);
endmodule

// ### psc_far_end.sv
// far-side model: cache, sram, l2 and link phy answer after a set delay
module psc_far_end
   import psc_pkg::*;
(
   // clock, reset and answer delay in cycles
   input wire logic i_sys_clk,
   input wire logic i_nrst,
   input wire logic [2:0] i_dly,
   // requests from the coordinator
   input wire logic i_flush_req,
   input wire logic [1:0] i_save_req,
   input wire logic i_shrink_req,
   input wire psc_pkg::psc_link_t i_link,
   // answers
   output logic o_flush_done,
   output logic [1:0] o_save_done,
   output logic o_shrink_done,
   output logic o_at_l0
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [4:0] rq;
   logic [4:0] ack;
   logic [7:0] sh [5];
   // one channel per request, so the two thread saves may finish apart
   assign rq = {i_link == PSC_L0, i_shrink_req, i_save_req, i_flush_req};
   // how long each request has stood; a dropped request starts over
   always_ff @(posedge i_sys_clk or negedge i_nrst) begin
      for (int i = 0; i < 5; i++) begin
         if (!i_nrst) sh[i] <= 8'h00;
         else sh[i] <= rq[i] ? {sh[i][6:0], 1'b1} : 8'h00;
      end
   end
   // answer only while the request still stands, never early
   always_comb begin
      for (int i = 0; i < 5; i++) ack[i] = rq[i] & sh[i][i_dly];
   end
   assign {o_at_l0, o_shrink_done, o_save_done, o_flush_done} = ack;
endmodule

// ### psc_properties.sv
// assertion checker on the power state coordinator ports
module psc_chk
   import psc_pkg::*;
(
   // clock and reset
   input wire logic i_sys_clk,
   input wire logic i_nrst,
   // watched inputs and outputs
   input wire psc_pkg::psc_sstate_t i_sleep_state,
   input wire logic i_banks_open,
   input wire logic i_link_pending,
   input wire logic i_link_at_l0,
   input wire psc_pkg::psc_cstate_t o_core_cstate,
   input wire logic o_core_clk_gate,
   input wire logic o_proc_clk_stop,
   input wire logic o_vcore_low,
   input wire logic o_vcore_off,
   input wire logic o_lfm_req,
   input wire logic o_uncore_pwr_off,
   input wire logic o_display_off,
   input wire logic o_flush_req,
   input wire logic o_l2_shrink_req,
   input wire psc_pkg::psc_mem_t o_mem_state,
   input wire logic o_mem_cke,
   input wire logic o_mem_self_refresh,
   input wire psc_pkg::psc_link_t o_chipset_link_state,
   input wire logic o_link_xfer_ok
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (!i_nrst);
   logic shrunk_r;
   // set once the deep sequence raised its shrink request since the last flush
   always_ff @(posedge i_sys_clk or negedge i_nrst) begin
      if (!i_nrst) shrunk_r <= 1'b0;
      else if (o_flush_req) shrunk_r <= 1'b0;
      else if (o_l2_shrink_req) shrunk_r <= 1'b1;
   end
   sequence s_shrink_end;
      o_l2_shrink_req ##1 !o_l2_shrink_req;
   endsequence
   a_mem_up_cke: assert property (o_mem_state == PSC_MEM_UP |-> o_mem_cke)
      else $error("clock enable low in active memory state");
   a_ppd_closed: assert property (o_mem_state == PSC_MEM_PPD |->
      !o_mem_cke && !o_mem_self_refresh && !$past(i_banks_open))
      else $error("precharge powerdown wrong");
   a_apd_open: assert property (o_mem_state == PSC_MEM_APD |->
      !o_mem_cke && !o_mem_self_refresh && $past(i_banks_open))
      else $error("active powerdown wrong");
   a_sr_cke: assert property (o_mem_self_refresh |->
      !o_mem_cke && o_mem_state == PSC_MEM_SR)
      else $error("self-refresh with clock enable");
   a_link_l1: assert property (o_chipset_link_state == PSC_L1 |->
      (o_core_cstate inside {PSC_C2, PSC_C3, PSC_C4}) ||
      ($past(o_core_cstate) inside {PSC_C2, PSC_C3, PSC_C4}))
      else $error("link L1 outside C2 to C4");
   a_link_l3: assert property (i_sleep_state != PSC_S0 |=> o_chipset_link_state == PSC_L3)
      else $error("link not off in sleep");
   a_sleep_off: assert property (i_sleep_state != PSC_S0 |=> o_display_off &&
      o_uncore_pwr_off && o_vcore_off && o_mem_self_refresh)
      else $error("sleep power state wrong");
   a_stop_clk: assert property (o_core_cstate == PSC_C2 |->
      o_core_clk_gate && !o_proc_clk_stop)
      else $error("stop clock state wrong");
   a_deeper_sleep: assert property (o_core_cstate inside {PSC_C3, PSC_C4} |->
      o_proc_clk_stop && o_vcore_low)
      else $error("deeper sleep state wrong");
   a_ext_lfm: assert property (o_lfm_req |->
      o_core_cstate inside {PSC_C1, PSC_C2, PSC_C4})
      else $error("low frequency outside extended states");
   a_shrink_off: assert property (s_shrink_end |-> ##[0:2] o_vcore_off)
      else $error("no voltage off after shrink");
   a_off_after: assert property ($rose(o_vcore_off) && i_sleep_state == PSC_S0 |->
      shrunk_r)
      else $error("voltage off before flush save shrink");
   a_xfer_l0: assert property (o_link_xfer_ok |-> i_link_at_l0)
      else $error("transfer allowed outside L0");
   a_pend_l0: assert property (i_link_pending && i_sleep_state == PSC_S0 |=>
      o_chipset_link_state == PSC_L0)
      else $error("link not full on with transfer pending");
endmodule
bind psc_top psc_chk u_chk (.*);

// ### tb_psc_top.sv
// self-checking bench for the power state coordinator
module tb_psc_top;
   timeunit 1ns;
   timeprecision 100ps;
   import psc_pkg::*;
   logic clk = 0, nrst = 0, ext = 0, midle = 0, banks = 0, lidle = 0, pend = 0;
   psc_sstate_t slp = PSC_S0;
   psc_cstate_t t0 = PSC_C0, t1 = PSC_C0, core;
   logic [2:0] dly = 3'h1;
   logic fd, hd, al0, gate, stop, vlow, voff, lfm, uoff, doff, fr, shreq, cke, sr, xok;
   logic [1:0] sd, sreq;
   logic [3:0] seen = 4'h0;
   psc_mem_t mst;
   psc_link_t lst;
   int err_total = 0, total_checks = 0, cyc = 0, wcnt, n1;
   // ==================== clock, timeout, design
   always #12.5 clk = ~clk;
   always @(posedge clk) begin
      // deep-step record starts over whenever neither thread asks for deep powerdown
      if (t0 == PSC_C6 || t1 == PSC_C6) seen <= seen | {shreq, sreq, fr};
      else seen <= 4'h0;
      cyc++;
      if (cyc == 20000) begin
         err_total++;
         stop_test;
      end
   end
   psc_top dut (.i_sys_clk(clk), .i_nrst(nrst), .i_sleep_state(slp), .i_thr0_cstate(t0),
      .i_thr1_cstate(t1), .i_ext_idle(ext), .i_flush_done(fd), .i_sram_save_done(sd),
      .i_shrink_done(hd), .i_mem_idle(midle), .i_banks_open(banks), .i_link_idle(lidle),
      .i_link_pending(pend), .i_link_at_l0(al0), .o_core_cstate(core), .o_core_clk_gate(gate),
      .o_proc_clk_stop(stop), .o_vcore_low(vlow), .o_vcore_off(voff), .o_lfm_req(lfm),
      .o_uncore_pwr_off(uoff), .o_display_off(doff), .o_flush_req(fr), .o_sram_save_req(sreq),
      .o_l2_shrink_req(shreq), .o_mem_state(mst), .o_mem_cke(cke), .o_mem_self_refresh(sr),
      .o_chipset_link_state(lst), .o_link_xfer_ok(xok));
   psc_far_end u_far (.i_sys_clk(clk), .i_nrst(nrst), .i_dly(dly), .i_flush_req(fr),
      .i_save_req(sreq), .i_shrink_req(shreq), .i_link(lst), .o_flush_done(fd),
      .o_save_done(sd), .o_shrink_done(hd), .o_at_l0(al0));
   // ==================== shared tasks
   task stop_test;
      if (err_total == 0 && total_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task chk(string n, logic [7:0] s, logic [7:0] e);
      total_checks++;
      if (s !== e) begin
         err_total++;
         $display("[ERR] %s exp %h got %h", n, e, s);
      end
   endtask
   // settle after the edge so registered outputs have landed
   task step(int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   // bounded wait; a wrong resolution runs out and shows in the compare
   task wait_core(psc_cstate_t e);
      wcnt = 0;
      while (core !== e && wcnt < 1000) begin
         step(1);
         wcnt++;
      end
   endtask
   // ==================== scenarios
   task t_mem;
      for (int b = 0; b < 2; b++) begin
         @(posedge clk);
         midle <= 1'b1;
         banks <= b[0];
         step(2);
         chk("mem_state", mst, b ? PSC_MEM_APD : PSC_MEM_PPD);
         chk("cke", {cke, sr}, 2'h0);
      end
      @(posedge clk);
      midle <= 1'b0;
      step(2);
      chk("mem_up", {mst, cke}, {PSC_MEM_UP, 1'b1});
   endtask
   task t_core(psc_cstate_t a, psc_cstate_t b, psc_cstate_t e, logic x);
      @(posedge clk);
      t0 <= a;
      t1 <= b;
      ext <= x;
      lidle <= 1'b1;
      wait_core(e);
      step(2);
      chk("core", core, e);
      chk("gate", gate, e >= PSC_C2);
      chk("stop", {stop, vlow}, {e >= PSC_C3, e inside {PSC_C3, PSC_C4}});
      chk("lfm", lfm, x && (e inside {PSC_C1, PSC_C2, PSC_C4}));
      chk("link", lst, (e inside {PSC_C2, PSC_C3, PSC_C4}) ? PSC_L1 : PSC_L0S);
   endtask
   task t_deep;
      @(posedge clk);
      dly <= 3'h5;
      t0 <= PSC_C6;
      t1 <= PSC_C6;
      wait_core(PSC_C6);
      step(2);
      chk("deep_steps", {seen, voff}, 5'h1f);
      chk("deep_link", lst, PSC_L0S);
      t_core(PSC_C0, PSC_C0, PSC_C0, 1'b0);
      chk("wake_volt", voff, 1'b0);
   endtask
   task t_sleep;
      for (int s = 3; s < 6; s++) begin
         @(posedge clk);
         slp <= psc_sstate_t'(s[2:0]);
         step(3);
         chk("sleep_link", lst, PSC_L3);
         chk("sleep_pwr", {doff, uoff, voff}, 3'h7);
         chk("sleep_mem", {sr, cke}, 2'h2);
      end
      @(posedge clk);
      slp <= PSC_S0;
      step(3);
      chk("wake_disp", doff, 1'b0);
   endtask
   // a pending transfer waits for the phy to report full-on
   task t_xfer;
      @(posedge clk);
      dly <= 3'h4;
      lidle <= 1'b0;
      pend <= 1'b1;
      step(1);
      chk("xfer_early", xok, 1'b0);
      step(8);
      chk("xfer_l0", {xok, lst}, {1'b1, PSC_L0});
   endtask
   // ==================== main sequence
   initial begin
      repeat (4) @(posedge clk);
      nrst <= 1'b1;
      t_mem;
      t_core(PSC_C1, PSC_C2, PSC_C1, 1'b1);
      n1 = wcnt;
      t_core(PSC_C2, PSC_C3, PSC_C2, 1'b1);
      t_core(PSC_C4, PSC_C4, PSC_C4, 1'b1);
      chk("latency", wcnt > n1, 1'b1);
      t_core(PSC_C3, PSC_C6, PSC_C3, 1'b0);
      t_core(PSC_C0, PSC_C0, PSC_C0, 1'b0);
      t_deep;
      t_sleep;
      t_xfer;
      stop_test;
   end
endmodule
